// file: rtl/pci_claim_pkg.sv
// Constants and types shared by the bus claim, lock and arbitration logic
package pci_claim_pkg;

  // Bus, interrupt source and wait counter widths
  localparam int unsigned AD_W      = 32;
  localparam int unsigned CBE_W     = 4;
  localparam int unsigned IRQ_SRC_W = 2;
  localparam int unsigned CNT_W     = 3;

  // Bus command codes seen on the command lines during the address phase
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;

  // Memory window claimed as a target
  localparam logic [31:0] TGT_BASE = 32'h8000_0000;
  localparam logic [31:0] TGT_MASK = 32'hFFF0_0000;

  // Bus clocks allowed for a target to claim before a master abort
  localparam logic [2:0] CLAIM_WAIT_CYC = 3'h6;

  // Interrupt source positions
  localparam int unsigned IRQ_ABORT_BIT = 0;
  localparam int unsigned IRQ_EXT_BIT   = 1;

  // Values after reset
  localparam logic [1:0] IRQ_PEND_RST = 2'h0;
  localparam logic [2:0] CNT_RST      = 3'h0;

  // Initiator side of a transaction
  typedef enum logic [1:0] {
    M_IDLE,
    M_ADDR,
    M_WAIT,
    M_END
  } master_state_t;

  // Target side of a transaction
  typedef enum logic {
    T_IDLE,
    T_CLAIM
  } target_state_t;

endpackage : pci_claim_pkg

// file: rtl/pci_claim_sync.sv
// Two flip-flop synchroniser for level and toggle signals
`timescale 1ns/100ps
`default_nettype none

module pci_claim_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Source level and synchronised copy
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : pci_claim_sync

`default_nettype wire

// file: rtl/pci_claim_lock_arbitration.sv
// Bus claim, target lock, bus request and interrupt logic of the packet engine
//
// Operation
// - As target, drive device select low when the address falls in our window.
// - As initiator, abort if no device select within six bus clocks of address.
// - A master abort raises an interrupt toward the host.
// - Float device select unless initiator or target; input as initiator, output as target.
// - Device select is driven and sampled on rising bus clock edges.
// - Lock and frame low while target: owner set, other initiators rejected.
// - Lock ends only when frame and lock are both seen high.
// - As initiator never lock a target; lock is input only.
// - Lock is sampled on rising bus clock edges.
// - Request low while host memory access is wanted, high otherwise.
// - Request changes only on rising bus clock edges.
// - Even with grant low, start only after frame is sampled high.
// - Grant is sampled on rising bus clock edges.
// - Interrupt pin pulled low while any unmasked source is active.
// - Interrupt pin released once the host acknowledges the source.
// - Interrupt pin is open drain, not aligned to the bus clock.
// - Selected configuration read or write claims with device select next clock.
`timescale 1ns/100ps
`default_nettype none

module pci_claim_lock_arbitration (
  // Core clock and reset
  input  wire logic                                  core_clk_in,
  input  wire logic                                  nrst_in,
  // Core side requests and controls
  input  wire logic                                  want_access_in,
  input  wire logic                                  ext_irq_in,
  input  wire logic [pci_claim_pkg::IRQ_SRC_W-1:0]   irq_mask_in,
  input  wire logic [pci_claim_pkg::IRQ_SRC_W-1:0]   irq_ack_in,
  // Core side status
  output var  logic                                  master_done_out,
  output var  logic                                  master_abort_out,
  output var  logic                                  target_reject_out,
  output var  logic                                  locked_out,
  output var  logic [pci_claim_pkg::IRQ_SRC_W-1:0]   irq_pending_out,
  // Bus clock
  input  wire logic                                  host_bus_clock,
  // Bus address phase
  input  wire logic [pci_claim_pkg::AD_W-1:0]        ad_in,
  input  wire logic [pci_claim_pkg::CBE_W-1:0]       cbe_n_in,
  input  wire logic                                  idsel_in,
  // Frame, two-way
  input  wire logic                                  frame_n_in,
  output var  logic                                  frame_n_out,
  output var  logic                                  frame_oe_out,
  // Device select, two-way
  input  wire logic                                  devsel_n_in,
  output var  logic                                  devsel_n_out,
  output var  logic                                  devsel_oe_out,
  // Lock, input only
  input  wire logic                                  lock_n_in,
  // Arbitration
  output var  logic                                  req_n_out,
  output var  logic                                  req_oe_out,
  input  wire logic                                  gnt_n_in,
  // Interrupt, open drain
  output var  logic                                  host_interrupt_n_out,
  output var  logic                                  host_interrupt_n_oe_out
);

  // ---------------- Bus clock domain ----------------
  pci_claim_pkg::master_state_t m_state_r;
  pci_claim_pkg::master_state_t m_state_nxt;
  pci_claim_pkg::target_state_t t_state_r;
  pci_claim_pkg::target_state_t t_state_nxt;
  logic [pci_claim_pkg::CNT_W-1:0] wait_cnt_r;
  logic [pci_claim_pkg::CNT_W-1:0] wait_cnt_nxt;
  logic                            frame_prev_r;
  logic                            lock_r;
  logic                            lock_nxt;
  logic                            done_tgl_r;
  logic                            done_tgl_nxt;
  logic                            abort_tgl_r;
  logic                            abort_tgl_nxt;
  logic                            reject_tgl_r;
  logic                            reject_tgl_nxt;
  logic                            frame_n_nxt;
  logic                            frame_oe_nxt;
  logic                            devsel_n_nxt;
  logic                            devsel_oe_nxt;
  logic                            req_n_nxt;
  logic                            want_bus;
  logic                            addr_phase;
  logic                            cfg_hit;
  logic                            mem_hit;
  logic                            not_owner;

  // Core wish to reach host memory, brought onto the bus clock
  pci_claim_sync #(
    .W (1)
  ) u_want_sync (
    .clk_in  (host_bus_clock),
    .nrst_in (nrst_in),
    .d_in    (want_access_in),
    .q_out   (want_bus)
  );

  // Address phase: frame seen high last edge, low now, not our own cycle
  assign addr_phase = frame_prev_r && !frame_n_in && (m_state_r == pci_claim_pkg::M_IDLE);
  assign cfg_hit    = idsel_in && ((cbe_n_in == pci_claim_pkg::CMD_CFG_RD) ||
                                   (cbe_n_in == pci_claim_pkg::CMD_CFG_WR));
  assign mem_hit    = ((cbe_n_in == pci_claim_pkg::CMD_MEM_RD) || (cbe_n_in == pci_claim_pkg::CMD_MEM_WR)) &&
                      ((ad_in & pci_claim_pkg::TGT_MASK) == pci_claim_pkg::TGT_BASE);
  // Owner re-enters with lock high in its address phase, others find it low
  assign not_owner  = lock_r && !lock_n_in;

  // Initiator sequence
  always_comb begin
    m_state_nxt   = m_state_r;
    wait_cnt_nxt  = wait_cnt_r;
    done_tgl_nxt  = done_tgl_r;
    abort_tgl_nxt = abort_tgl_r;
    unique case (m_state_r)
      pci_claim_pkg::M_IDLE: begin
        if (want_bus && !gnt_n_in && frame_n_in && (t_state_r == pci_claim_pkg::T_IDLE)) begin
          m_state_nxt = pci_claim_pkg::M_ADDR;
        end
      end
      pci_claim_pkg::M_ADDR: begin
        m_state_nxt  = pci_claim_pkg::M_WAIT;
        wait_cnt_nxt = pci_claim_pkg::CNT_RST;
      end
      pci_claim_pkg::M_WAIT: begin
        if (!devsel_n_in) begin
          m_state_nxt  = pci_claim_pkg::M_END;
          done_tgl_nxt = !done_tgl_r;
        end else if (wait_cnt_r == pci_claim_pkg::CLAIM_WAIT_CYC - 3'h1) begin
          m_state_nxt   = pci_claim_pkg::M_END;
          abort_tgl_nxt = !abort_tgl_r;
        end else begin
          wait_cnt_nxt = wait_cnt_r + 3'h1;
        end
      end
      pci_claim_pkg::M_END: begin
        m_state_nxt = pci_claim_pkg::M_IDLE;
      end
    endcase
    // Frame low through address and wait, driven high one clock, then floated
    frame_oe_nxt = (m_state_nxt != pci_claim_pkg::M_IDLE);
    frame_n_nxt  = (m_state_nxt == pci_claim_pkg::M_IDLE) || (m_state_nxt == pci_claim_pkg::M_END);
    req_n_nxt    = !want_bus;
  end

  // Target claim and lock ownership
  always_comb begin
    t_state_nxt    = t_state_r;
    lock_nxt       = lock_r;
    reject_tgl_nxt = reject_tgl_r;
    unique case (t_state_r)
      pci_claim_pkg::T_IDLE: begin
        if (addr_phase && (cfg_hit || mem_hit)) begin
          if (not_owner) begin
            reject_tgl_nxt = !reject_tgl_r;
          end else begin
            t_state_nxt = pci_claim_pkg::T_CLAIM;
          end
        end
      end
      pci_claim_pkg::T_CLAIM: begin
        if (frame_n_in) begin
          t_state_nxt = pci_claim_pkg::T_IDLE;
        end
      end
    endcase
    // Lock is only ever watched, never driven
    if ((t_state_r == pci_claim_pkg::T_CLAIM) && !lock_n_in && !frame_n_in) begin
      lock_nxt = 1'b1;
    end else if (lock_n_in && frame_n_in) begin
      lock_nxt = 1'b0;
    end
    // Drive only while claiming, float otherwise
    devsel_oe_nxt = (t_state_nxt == pci_claim_pkg::T_CLAIM);
    devsel_n_nxt  = !devsel_oe_nxt;
  end

  always_ff @(posedge host_bus_clock or negedge nrst_in) begin
    if (!nrst_in) begin
      m_state_r     <= pci_claim_pkg::M_IDLE;
      t_state_r     <= pci_claim_pkg::T_IDLE;
      wait_cnt_r    <= pci_claim_pkg::CNT_RST;
      frame_prev_r  <= 1'b1;
      lock_r        <= 1'b0;
      done_tgl_r    <= 1'b0;
      abort_tgl_r   <= 1'b0;
      reject_tgl_r  <= 1'b0;
      frame_n_out   <= 1'b1;
      frame_oe_out  <= 1'b0;
      devsel_n_out  <= 1'b1;
      devsel_oe_out <= 1'b0;
      req_n_out     <= 1'b1;
      req_oe_out    <= 1'b0;
    end else begin
      m_state_r     <= m_state_nxt;
      t_state_r     <= t_state_nxt;
      wait_cnt_r    <= wait_cnt_nxt;
      frame_prev_r  <= frame_n_in;
      lock_r        <= lock_nxt;
      done_tgl_r    <= done_tgl_nxt;
      abort_tgl_r   <= abort_tgl_nxt;
      reject_tgl_r  <= reject_tgl_nxt;
      frame_n_out   <= frame_n_nxt;
      frame_oe_out  <= frame_oe_nxt;
      devsel_n_out  <= devsel_n_nxt;
      devsel_oe_out <= devsel_oe_nxt;
      req_n_out     <= req_n_nxt;
      req_oe_out    <= 1'b1;
    end
  end

  // ---------------- Core clock domain ----------------
  logic [2:0]                            evt_core;
  logic [2:0]                            evt_seen_r;
  logic [2:0]                            evt_seen_nxt;
  logic [pci_claim_pkg::IRQ_SRC_W-1:0]   pend_r;
  logic [pci_claim_pkg::IRQ_SRC_W-1:0]   pend_nxt;
  logic [pci_claim_pkg::IRQ_SRC_W-1:0]   src;
  logic                                  done_nxt;
  logic                                  abort_nxt;
  logic                                  reject_nxt;
  logic                                  int_oe_nxt;
  logic                                  lock_core;

  // Event toggles and lock level carried back to the core clock
  pci_claim_sync #(
    .W (4)
  ) u_evt_sync (
    .clk_in  (core_clk_in),
    .nrst_in (nrst_in),
    .d_in    ({lock_r, reject_tgl_r, abort_tgl_r, done_tgl_r}),
    .q_out   ({lock_core, evt_core})
  );

  always_comb begin
    evt_seen_nxt = evt_core;
    done_nxt     = evt_core[0] ^ evt_seen_r[0];
    abort_nxt    = evt_core[1] ^ evt_seen_r[1];
    reject_nxt   = evt_core[2] ^ evt_seen_r[2];
    src          = '0;
    src[pci_claim_pkg::IRQ_ABORT_BIT] = abort_nxt;
    src[pci_claim_pkg::IRQ_EXT_BIT]   = ext_irq_in;
    // New event wins over a same-cycle acknowledge
    pend_nxt     = (pend_r & ~irq_ack_in) | src;
    int_oe_nxt   = |(pend_nxt & ~irq_mask_in);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      evt_seen_r              <= 3'h0;
      pend_r                  <= pci_claim_pkg::IRQ_PEND_RST;
      master_done_out         <= 1'b0;
      master_abort_out        <= 1'b0;
      target_reject_out       <= 1'b0;
      locked_out              <= 1'b0;
      host_interrupt_n_oe_out <= 1'b0;
    end else begin
      evt_seen_r              <= evt_seen_nxt;
      pend_r                  <= pend_nxt;
      master_done_out         <= done_nxt;
      master_abort_out        <= abort_nxt;
      target_reject_out       <= reject_nxt;
      locked_out              <= lock_core;
      host_interrupt_n_oe_out <= int_oe_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign host_interrupt_n_out = 1'b0;
  assign irq_pending_out      = pend_r;

endmodule : pci_claim_lock_arbitration

`default_nettype wire

// file: bench/pci_claim_checker.sv
// Assertion checker for the bus claim, lock, request and interrupt logic
`timescale 1ns/100ps
`default_nettype none

module pci_claim_checker (
  // Core domain
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       ext_irq_in,
  input wire logic [1:0] irq_mask_in,
  input wire logic [1:0] irq_ack_in,
  input wire logic       master_abort_out,
  input wire logic [1:0] irq_pending_out,
  input wire logic       host_interrupt_n_out,
  input wire logic       host_interrupt_n_oe_out,
  // Bus domain
  input wire logic       host_bus_clock,
  input wire logic       want_access_in,
  input wire logic [3:0] cbe_n_in,
  input wire logic       idsel_in,
  input wire logic       frame_n_in,
  input wire logic       frame_n_out,
  input wire logic       frame_oe_out,
  input wire logic       devsel_n_in,
  input wire logic       devsel_n_out,
  input wire logic       devsel_oe_out,
  input wire logic       lock_n_in,
  input wire logic       req_n_out,
  input wire logic       gnt_n_in
);
  property p_cfg_claim;
    @(posedge host_bus_clock) disable iff (!nrst_in) !frame_n_in && $past(frame_n_in) && $past(gnt_n_in) && idsel_in
      && cbe_n_in[3:1] == 3'h5 && lock_n_in && !frame_oe_out |=> devsel_oe_out && !devsel_n_out;
  endproperty
  a_cfg_claim: assert property (p_cfg_claim) else $error("config cycle not claimed");
  property p_release;
    @(posedge host_bus_clock) disable iff (!nrst_in) devsel_oe_out && frame_n_in |=> !devsel_oe_out && devsel_n_out;
  endproperty
  a_release: assert property (p_release) else $error("device select not floated");
  property p_abort;
    @(posedge host_bus_clock) disable iff (!nrst_in)
      $rose(frame_oe_out) ##0 devsel_n_in [*7] |=> frame_oe_out && frame_n_out;
  endproperty
  a_abort: assert property (p_abort) else $error("unclaimed cycle not aborted");
  property p_start_gate;
    @(posedge host_bus_clock) disable iff (!nrst_in) $rose(frame_oe_out) |-> $past(frame_n_in) && !$past(gnt_n_in);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start without idle bus and grant");
  property p_req;
    @(posedge host_bus_clock) disable iff (!nrst_in) want_access_in [*5] |-> !req_n_out;
  endproperty
  a_req: assert property (p_req) else $error("request not low while wanted");
  property p_abort_irq;
    @(posedge core_clk_in) disable iff (!nrst_in) master_abort_out |-> ##[0:1] irq_pending_out[0];
  endproperty
  a_abort_irq: assert property (p_abort_irq) else $error("abort left no pending interrupt");
  property p_irq_pin;
    @(posedge core_clk_in) disable iff (!nrst_in)
      host_interrupt_n_oe_out == |(irq_pending_out & ~$past(irq_mask_in));
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin disagrees with sources");
  property p_ack;
    @(posedge core_clk_in) disable iff (!nrst_in) irq_ack_in[1] && !ext_irq_in |=> !irq_pending_out[1];
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not clear");
  property p_od;
    @(posedge core_clk_in) disable iff (!nrst_in) !host_interrupt_n_out;
  endproperty
  a_od: assert property (p_od) else $error("interrupt pin drives high");
endmodule : pci_claim_checker

bind pci_claim_lock_arbitration pci_claim_checker pci_claim_checker_i (.*);

`default_nettype wire

// file: bench/pci_far_agent.sv
// Arbiter and foreign target facing the engine on the host bus
`timescale 1ns/100ps
`default_nettype none

module pci_far_agent (
  // Bus clock and reset
  input  wire logic       host_bus_clock,
  input  wire logic       nrst_in,
  // Bus levels seen
  input  wire logic       req_n_in,
  input  wire logic       frame_n_in,
  input  wire logic       frame_oe_in,
  // Claim delay in bus clocks, 0 never claims
  input  wire logic [2:0] claim_lat_in,
  // Far side drive, device select pulled up when released
  output var  logic       gnt_n_out,
  output var  logic       devsel_n_out
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       devsel_nxt;
  always_comb begin
    cnt_nxt    = frame_oe_in ? ((cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1) : 3'h0;
    devsel_nxt = !(claim_lat_in != 3'h0 && cnt_r >= claim_lat_in && frame_oe_in && !frame_n_in);
  end
  always_ff @(posedge host_bus_clock or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r        <= 3'h0;
      gnt_n_out    <= 1'b1;
      devsel_n_out <= 1'b1;
    end else begin
      cnt_r        <= cnt_nxt;
      gnt_n_out    <= req_n_in;
      devsel_n_out <= devsel_nxt;
    end
  end
endmodule : pci_far_agent

`default_nettype wire

// file: bench/tb_pci_claim_lock_arbitration.sv
// Self-checking bench for the bus claim, lock, request and interrupt logic
`timescale 1ns/100ps
`default_nettype none

module tb_pci_claim_lock_arbitration;
  logic        core_clk_in, host_bus_clock, nrst_in, want_access_in, ext_irq_in, idsel_in, lock_n_in, gnt_n_in;
  logic [1:0]  irq_mask_in, irq_ack_in, irq_pending_out;
  logic [31:0] ad_in, seed, r, a;
  logic [3:0]  cbe_n_in, c;
  logic [2:0]  lat;
  logic        master_done_out, master_abort_out, target_reject_out, locked_out, frame_n_out, frame_oe_out;
  logic        devsel_n_out, devsel_oe_out, req_n_out, req_oe_out, host_interrupt_n_out, host_interrupt_n_oe_out;
  logic        tb_frame_n, agent_devsel, rej_seen;
  int          bad_count, cmp_count;
  wire logic   frame_n_in  = frame_oe_out ? frame_n_out : tb_frame_n;
  wire logic   devsel_n_in = devsel_oe_out ? devsel_n_out : agent_devsel;
  localparam logic [31:0] tgt_ad [8] = '{32'h8000_0000, 32'h800F_FFFC, 32'h8010_0000, 32'h7FFF_FFFC,
                                          32'h0000_0000, 32'h1234_5678, 32'h0000_0040, 32'h8010_0000};
  localparam logic [3:0]  tgt_cmd [8] = '{4'h6, 4'h7, 4'h6, 4'h7, 4'hA, 4'hB, 4'hA, 4'h6};
  localparam logic [7:0]  tgt_sel = 8'hB0;
  localparam logic [2:0]  lats [4] = '{3'h1, 3'h4, 3'h5, 3'h0};

  pci_claim_lock_arbitration pci_claim_lock_arbitration_i (.*);
  pci_far_agent pci_far_agent_i (.host_bus_clock, .nrst_in, .req_n_in(req_n_out), .frame_n_in(frame_n_in),
    .frame_oe_in(frame_oe_out), .claim_lat_in(lat), .gnt_n_out(gnt_n_in), .devsel_n_out(agent_devsel));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = !core_clk_in;
  end
  initial begin
    host_bus_clock = 1'b0;
    #1.7;
    forever #3 host_bus_clock = !host_bus_clock;
  end
  always @(posedge core_clk_in) if (target_reject_out === 1'b1) rej_seen <= 1'b1;

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function logic hit(input logic [31:0] ad, input logic [3:0] cmd, input logic sel);
    return (cmd[3:1] == 3'h3 && (ad & pci_claim_pkg::TGT_MASK) == pci_claim_pkg::TGT_BASE) || (sel && cmd[3:1] == 3'h5);
  endfunction : hit
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // Another initiator's cycle: address, one data clock, frame high
  task automatic tgt(input logic [31:0] ad, input logic [3:0] cmd, input logic s, la, lb, e);
    @(negedge host_bus_clock);
    tb_frame_n = 1'b0;
    ad_in = ad;
    cbe_n_in = cmd;
    idsel_in = s;
    lock_n_in = la;
    @(negedge host_bus_clock);
    ad_in = ~ad;
    cbe_n_in = ~cmd;
    idsel_in = !s;
    lock_n_in = lb;
    chk(devsel_oe_out, e);
    chk(devsel_n_out, !e);
    @(negedge host_bus_clock);
    tb_frame_n = 1'b1;
    repeat (2) @(negedge host_bus_clock);
    chk(devsel_oe_out, 1'b0);
  endtask : tgt
  // Own initiator cycle, optionally behind a busy bus
  task automatic ini(input logic [2:0] l, input logic hold);
    int   n;
    logic ab;
    ab = l == 3'h0 || l > 3'h5;
    @(negedge host_bus_clock);
    lat = l;
    ad_in = 32'h0000_0000;
    cbe_n_in = 4'h6;
    idsel_in = 1'b0;
    if (hold) tb_frame_n = 1'b0;
    @(negedge core_clk_in);
    want_access_in = 1'b1;
    if (hold) begin
      repeat (20) @(negedge core_clk_in);
      chk(frame_oe_out, 1'b0);
      @(negedge host_bus_clock);
      tb_frame_n = 1'b1;
    end
    n = 0;
    while (master_done_out !== 1'b1 && master_abort_out !== 1'b1 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    chk(master_abort_out, ab);
    chk(master_done_out, !ab);
    chk(req_n_out, 1'b0);
    chk(req_oe_out, 1'b1);
    want_access_in = 1'b0;
    repeat (30) @(negedge core_clk_in);
    chk(req_n_out, 1'b1);
    chk(irq_pending_out[0], ab);
    chk(host_interrupt_n_oe_out, ab);
    irq_ack_in = 2'h1;
    @(negedge core_clk_in);
    irq_ack_in = 2'h0;
    repeat (2) @(negedge core_clk_in);
    chk(host_interrupt_n_oe_out, 1'b0);
  endtask : ini

  initial begin
    seed = 32'h0000_BD18;
    {want_access_in, ext_irq_in, idsel_in, irq_mask_in, irq_ack_in, nrst_in, rej_seen} = '0;
    {tb_frame_n, lock_n_in, ad_in, cbe_n_in, lat} = {2'h3, 32'h0000_0000, 4'hF, 3'h1};
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk(req_oe_out, 1'b0);
    chk(devsel_oe_out, 1'b0);
    chk(frame_oe_out, 1'b0);
    nrst_in = 1'b1;
    for (int i = 0; i < 8; i++) ini(i < 4 ? lats[i] : 3'(xs() % 6), i == 0);
    $display("test initiator done");
    for (int i = 0; i < 8; i++) tgt(tgt_ad[i], tgt_cmd[i], tgt_sel[i], 1'b1, 1'b1, hit(tgt_ad[i], tgt_cmd[i], tgt_sel[i]));
    for (int i = 0; i < 8; i++) begin
      r = xs();
      a = {r[0] ? 12'h800 : r[31:20], r[19:2], 2'h0};
      c = tgt_cmd[r[7:5]];
      tgt(a, c, r[4], 1'b1, 1'b1, hit(a, c, r[4]));
    end
    $display("test target done");
    tgt(32'h8000_0100, 4'h7, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge core_clk_in);
    chk(locked_out, 1'b1);
    chk(rej_seen, 1'b0);
    tgt(32'h8000_0200, 4'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (8) @(negedge core_clk_in);
    chk(rej_seen, 1'b1);
    tgt(32'h8000_0300, 4'h6, 1'b0, 1'b1, 1'b0, 1'b1);
    chk(locked_out, 1'b1);
    @(negedge host_bus_clock);
    lock_n_in = 1'b1;
    repeat (8) @(negedge core_clk_in);
    chk(locked_out, 1'b0);
    tgt(32'h8000_0400, 4'h6, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test lock done");
    irq_mask_in = 2'h2;
    ext_irq_in = 1'b1;
    @(negedge core_clk_in);
    ext_irq_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    chk(irq_pending_out, 2'h2);
    chk(host_interrupt_n_oe_out, 1'b0);
    irq_mask_in = 2'h0;
    repeat (2) @(negedge core_clk_in);
    chk(host_interrupt_n_oe_out, 1'b1);
    chk(host_interrupt_n_out, 1'b0);
    irq_ack_in = 2'h2;
    @(negedge core_clk_in);
    irq_ack_in = 2'h0;
    repeat (2) @(negedge core_clk_in);
    chk(host_interrupt_n_oe_out, 1'b0);
    $display("test interrupt done");
    end_of_test();
  end
  initial begin
    #500_000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_pci_claim_lock_arbitration

`default_nettype wire
